// >>> verilog/fsil_pkg.sv
// constants, types and register map of the fieldbus slave interrupt logic
// assumes a 250 MHz system clock and cycle events delivered as one-cycle pulses
// Functional notes
// R01: a source requests only while its enable bit is one; zero masks it.
// R02: reset clears every enable bit, so all sources start masked.
// R03: processor reads event registers only after a request, never by polling.
// R04: watchdog expiry flags bus-inactive, drops bus-active, leaves data registers intact.
// R05: parameter-channel send event at end of every data or identification cycle.
// R06: parameter-channel receive event at end of valid data cycle with idle bit one.
// R07: entering bus reset flags the bus-reset event and clears process data.
// R08: processor software always handles the bus-reset event.
// R09: write n to address 8; after n valid data cycles raise cycle-counter event.
// R10: while the cycle counter runs, reading address 8 returns its count.
// R11: completed identification cycle raises the identification-cycle event.
// R12: end of each valid data cycle raises the valid-data event.
// R13: invalid data cycle raises invalid-data event; output bytes stay from last valid.
// R14: check-sequence start raises an event; processor finishes accesses within 60 us.
// R15: no valid cycle within 50/200/1000 ms resets process data; off disables it.
// R16: link-layer timeout emits one 375 ns low pulse on external register reset.
// R17: timeout period comes only from the bus master, not the processor.
// R18: link-layer timeout is reported to the processor as an event.
// R19: an enabled event sets its event bit and drives the request line low.
// R20: reading an event register clears it and releases the request line.
// R21: request stays asserted while any enabled event bit remains pending.
package fsil_pkg;

  localparam int unsigned CLK_MHZ         = 250;
  localparam int unsigned TICK_NS         = 1000;
  localparam int unsigned TICK_CYC        = TICK_NS * CLK_MHZ / 1000;
  localparam int unsigned EXTERNAL_REGISTER_RESET_N_PULSE_NS = 375;
  localparam int unsigned EXTERNAL_REGISTER_RESET_N_CYC      = (EXTERNAL_REGISTER_RESET_N_PULSE_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned CHECK_WINDOW_US = 60;
  localparam int unsigned LT_SHORT_MS     = 50;
  localparam int unsigned LT_MID_MS       = 200;
  localparam int unsigned LT_LONG_MS      = 1000;
  localparam int unsigned TICKS_PER_MS    = 1000 / (TICK_NS / 1000);

  localparam logic [3:0] ADR_EV1    = 4'h4;
  localparam logic [3:0] ADR_EN1    = 4'h4;
  localparam logic [3:0] ADR_EV2    = 4'h5;
  localparam logic [3:0] ADR_CYC    = 4'h8;
  localparam logic [3:0] ADR_CYC_M1 = 4'h6;
  localparam logic [3:0] ADR_CYC_M2 = 4'hE;
  localparam logic [3:0] ADR_EN2    = 4'hE;

  localparam logic [7:0] EN_RESET = 8'h00;
  localparam logic [7:0] EV_RESET = 8'h00;
  localparam logic [7:0] CC_RESET = 8'h00;

  // event I / enable I positions
  localparam int unsigned B1_INACT = 0;
  localparam int unsigned B1_SEND  = 1;
  localparam int unsigned B1_RECV  = 2;
  localparam int unsigned B1_BRST  = 3;
  localparam int unsigned B1_CYC   = 4;
  localparam int unsigned B1_IDC   = 5;
  localparam int unsigned B1_DCYC  = 6;
  // event II positions
  localparam int unsigned B2_CHK   = 0;
  localparam int unsigned B2_VALID = 1;
  localparam int unsigned B2_INVAL = 2;
  localparam int unsigned B2_LT    = 3;
  // enable II positions
  localparam int unsigned E2_CHK   = 0;
  localparam int unsigned E2_LT    = 1;

  typedef enum logic [1:0] {
    FSIL_LT_OFF,
    FSIL_LT_SHORT,
    FSIL_LT_MID,
    FSIL_LT_LONG
  } fsil_lt_sel_e;

  typedef struct packed {
    logic data_valid;
    logic data_invalid;
    logic id_end;
    logic idle_bit;
    logic check_seq;
    logic bus_reset;
    logic user_update;
  } fsil_evt_s;

endpackage

// >>> verilog/fsil_timer.sv
// restartable timeout counter stepped by a slow tick enable
// assumes tick is a one-cycle pulse; holds after expiry until restarted
`timescale 1ns/1ps
`default_nettype none
module fsil_timer #(
  parameter int unsigned CNT_W = 20
) (
  input  wire logic             clk,     // system clock
  input  wire logic             rstn,    // async reset, active low
  input  wire logic             tick,    // slow time base enable
  input  wire logic             restart, // clear count and re-arm
  input  wire logic             enable,  // zero keeps the timer idle
  input  wire logic [CNT_W-1:0] limit,   // ticks until expiry
  output logic                  expire   // one-cycle expiry pulse
);

  initial begin
    if (CNT_W < 2 || CNT_W > 31) $error("fsil_timer: CNT_W out of range");
  end

  logic [CNT_W-1:0] cnt_ff;
  logic [CNT_W-1:0] nxt_cnt;
  logic             done_ff;
  logic             nxt_done;
  logic             hit;

  always_comb begin
    nxt_cnt  = cnt_ff;
    nxt_done = done_ff;
    hit      = 1'b0;
    if (restart || !enable) begin
      nxt_cnt  = '0;
      nxt_done = 1'b0;
    end else if (tick && !done_ff) begin
      if (cnt_ff + CNT_W'(1) >= limit) begin
        hit      = 1'b1;
        nxt_done = 1'b1;
        nxt_cnt  = '0;
      end else begin
        nxt_cnt = cnt_ff + CNT_W'(1);
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cnt_ff  <= '0;
      done_ff <= 1'b0;
      expire  <= 1'b0;
    end else begin
      cnt_ff  <= nxt_cnt;
      done_ff <= nxt_done;
      expire  <= hit;
    end
  end

endmodule
`default_nettype wire

// >>> verilog/fsil_top.sv
// interrupt logic of the fieldbus slave: event latching, enables, request line,
// cycle counter, bus-activity watchdog and link-layer timeout
// assumes cycle events arrive as one-cycle pulses from the protocol engine and
// processor port pins are already synchronous to clk
`timescale 1ns/1ps
`default_nettype none
module fsil_top
  import fsil_pkg::*;
#(
  parameter int unsigned LT_SHORT_TICKS = LT_SHORT_MS * TICKS_PER_MS,
  parameter int unsigned LT_MID_TICKS   = LT_MID_MS * TICKS_PER_MS,
  parameter int unsigned LT_LONG_TICKS  = LT_LONG_MS * TICKS_PER_MS,
  parameter int unsigned TICK_CYCLES    = TICK_CYC,
  parameter int unsigned WD_W           = 16
) (
  input  wire logic         clk,                       // system clock
  input  wire logic         rstn,                      // power-up reset, active low
  input  wire logic [3:0]   adr,                       // processor register address
  input  wire logic         cs_n,                      // chip select, active low
  input  wire logic         rd_n,                      // read strobe, active low
  input  wire logic         wr_n,                      // write strobe, active low
  input  wire logic [7:0]   data_i,                    // data pins, input side
  output logic [7:0]        data_o,                    // data pins, output side
  output logic              data_oe_n,                 // low while driving data pins
  output logic              irq_n,                     // interrupt request, active low
  input  wire fsil_evt_s    evt,                       // bus cycle events
  input  wire fsil_lt_sel_e link_layer_timeout_sel,    // period set by the bus master
  input  wire logic [WD_W-1:0] wd_limit_us,            // watchdog period, zero is off
  output logic              bus_active,                // bus-active diagnostic
  output logic              process_data_clear,        // pulse: clear process data
  output logic              external_register_reset_n  // 375 ns low pulse on timeout
);

  // shared timer width must hold both the longest timeout and the full watchdog field
  localparam int unsigned LT_W = ($clog2(LT_LONG_TICKS + 1) > WD_W) ?
                                 $clog2(LT_LONG_TICKS + 1) : WD_W;
  localparam int unsigned DIV_W = $clog2(TICK_CYCLES + 1);

  initial begin
    if (TICK_CYCLES < 2) $error("fsil_top: TICK_CYCLES too small");
    if (LT_SHORT_TICKS == 0 || LT_MID_TICKS == 0 || LT_LONG_TICKS == 0)
      $error("fsil_top: timeout ticks must be nonzero");
    if (LT_LONG_TICKS < LT_MID_TICKS || LT_MID_TICKS < LT_SHORT_TICKS)
      $error("fsil_top: timeout ticks must rise with the period");
    if (WD_W < 2 || WD_W > 30) $error("fsil_top: WD_W out of range");
  end

  function automatic logic [LT_W-1:0] lt_limit(input fsil_lt_sel_e sel);
    unique case (sel)
      FSIL_LT_SHORT: lt_limit = LT_W'(LT_SHORT_TICKS);
      FSIL_LT_MID:   lt_limit = LT_W'(LT_MID_TICKS);
      FSIL_LT_LONG:  lt_limit = LT_W'(LT_LONG_TICKS);
      default:       lt_limit = '0;
    endcase
  endfunction

  typedef enum logic {CC_IDLE, CC_RUN} fsil_cc_e;

  // processor port strobes
  logic              rd_act;
  logic              wr_act;
  logic              rd_act_ff;
  logic              wr_act_ff;
  logic [3:0]        adr_ff;
  logic [7:0]        wdat_ff;
  logic              rd_end;
  logic              wr_end;
  logic [7:0]        data_o_ff;
  logic [7:0]        nxt_data_o;
  logic              oe_n_ff;

  assign rd_act = !cs_n && !rd_n;
  assign wr_act = !cs_n && !wr_n;
  // access completes on the release edge of the strobe or select
  assign rd_end = rd_act_ff && !rd_act;
  assign wr_end = wr_act_ff && !wr_act;

  // register state
  logic [7:0]        en1_ff;
  logic [7:0]        nxt_en1;
  logic [7:0]        en2_ff;
  logic [7:0]        nxt_en2;
  logic [7:0]        ev1_ff;
  logic [7:0]        nxt_ev1;
  logic [7:0]        ev2_ff;
  logic [7:0]        nxt_ev2;
  logic [7:0]        set1;
  logic [7:0]        set2;
  logic [7:0]        cc_ff;
  logic [7:0]        nxt_cc;
  fsil_cc_e          cc_st_ff;
  fsil_cc_e          nxt_cc_st;
  logic              cc_fire;
  logic              irq_ff;
  logic              nxt_irq;

  // time base and timers
  logic [DIV_W-1:0]  div_ff;
  logic [DIV_W-1:0]  nxt_div;
  logic              tick;
  logic              wd_expire;
  logic              lt_expire;
  logic              ba_ff;
  logic              nxt_ba;
  logic [7:0]        rr_ff;
  logic [7:0]        nxt_rr;
  logic              clr_ff;
  logic              nxt_clr;

  always_comb begin
    tick    = (div_ff == DIV_W'(TICK_CYCLES - 1));
    nxt_div = tick ? '0 : div_ff + DIV_W'(1);
  end

  // watchdog: runs only while the bus is seen active
  fsil_timer #(
    .CNT_W (LT_W)
  ) u_wd (
    .clk     (clk),
    .rstn    (rstn),
    .tick    (tick),
    .restart (evt.user_update),
    .enable  (ba_ff && (wd_limit_us != '0)),
    .limit   (LT_W'(wd_limit_us)),
    .expire  (wd_expire)
  );

  // period select is a master-driven input only; no processor register reaches it
  fsil_timer #(
    .CNT_W (LT_W)
  ) u_lt (
    .clk     (clk),
    .rstn    (rstn),
    .tick    (tick),
    .restart (evt.data_valid || evt.id_end),
    .enable  (link_layer_timeout_sel != FSIL_LT_OFF),      // [R15] [R17]
    .limit   (lt_limit(link_layer_timeout_sel)),
    .expire  (lt_expire)
  );

  // cycle counter
  always_comb begin
    nxt_cc    = cc_ff;
    nxt_cc_st = cc_st_ff;
    cc_fire   = 1'b0;
    if (wr_end && adr_ff == ADR_CYC) begin
      nxt_cc    = wdat_ff;                                  // [R09]
      nxt_cc_st = (wdat_ff != 8'h00) ? CC_RUN : CC_IDLE;
    end else begin
      unique case (cc_st_ff)
        CC_IDLE: nxt_cc_st = CC_IDLE;
        CC_RUN: begin
          if (evt.data_valid) begin
            nxt_cc = cc_ff - 8'h01;                         // [R09]
            if (cc_ff == 8'h01) begin
              cc_fire   = 1'b1;
              nxt_cc_st = CC_IDLE;
            end
          end
        end
      endcase
    end
  end

  // event sources, each gated by its enable bit
  always_comb begin
    set1           = 8'h00;
    set2           = 8'h00;
    set1[B1_INACT] = en1_ff[B1_INACT] && wd_expire;                            // [R01] [R04]
    set1[B1_SEND]  = en1_ff[B1_SEND] && (evt.data_valid || evt.data_invalid
                     || evt.id_end);                                           // [R05]
    set1[B1_RECV]  = en1_ff[B1_RECV] && evt.data_valid && evt.idle_bit;        // [R06]
    set1[B1_BRST]  = en1_ff[B1_BRST] && evt.bus_reset;                         // [R07]
    set1[B1_CYC]   = en1_ff[B1_CYC] && cc_fire;                                // [R09]
    set1[B1_IDC]   = en1_ff[B1_IDC] && evt.id_end;                             // [R11]
    set2[B2_VALID] = en1_ff[B1_DCYC] && evt.data_valid;                        // [R12]
    set2[B2_INVAL] = en1_ff[B1_DCYC] && evt.data_invalid;                      // [R13]
    set2[B2_CHK]   = en2_ff[E2_CHK] && evt.check_seq;                          // [R14]
    set2[B2_LT]    = en2_ff[E2_LT] && lt_expire;                               // [R18]
  end

  // a read clears its register; a coincident event still sets its bit
  always_comb begin
    nxt_ev1 = ((rd_end && adr_ff == ADR_EV1) ? EV_RESET : ev1_ff) | set1;   // [R20] [R19]
    nxt_ev2 = ((rd_end && adr_ff == ADR_EV2) ? EV_RESET : ev2_ff) | set2;   // [R20] [R19]
    nxt_en1 = (wr_end && adr_ff == ADR_EN1) ? wdat_ff : en1_ff;             // [R01]
    nxt_en2 = (wr_end && adr_ff == ADR_EN2) ? wdat_ff : en2_ff;             // [R01]
  end

  // request held while any enabled bit is pending; masking later drops it
  always_comb begin
    nxt_irq = 1'b0;
    if ((nxt_ev1[B1_INACT] && en1_ff[B1_INACT]) || (nxt_ev1[B1_SEND] && en1_ff[B1_SEND]) ||
        (nxt_ev1[B1_RECV] && en1_ff[B1_RECV]) || (nxt_ev1[B1_BRST] && en1_ff[B1_BRST]) ||
        (nxt_ev1[B1_CYC] && en1_ff[B1_CYC]) || (nxt_ev1[B1_IDC] && en1_ff[B1_IDC]) ||
        ((nxt_ev2[B2_VALID] || nxt_ev2[B2_INVAL]) && en1_ff[B1_DCYC]) ||
        (nxt_ev2[B2_CHK] && en2_ff[E2_CHK]) || (nxt_ev2[B2_LT] && en2_ff[E2_LT]))
      nxt_irq = 1'b1;                                                       // [R21] [R19]
  end

  // bus activity, process data clear and external register reset pulse
  always_comb begin
    nxt_ba  = ba_ff;
    if (evt.user_update)
      nxt_ba = 1'b1;
    if (wd_expire)
      nxt_ba = 1'b0;                                                        // [R04]
    if (evt.bus_reset)
      nxt_ba = 1'b0;
    // watchdog expiry leaves data alone; only reset and timeout clear it
    nxt_clr = evt.bus_reset || lt_expire;                                   // [R07] [R15]
    nxt_rr  = (rr_ff != 8'h00) ? rr_ff - 8'h01 : 8'h00;
    if (lt_expire)
      nxt_rr = 8'(EXTERNAL_REGISTER_RESET_N_CYC);                                              // [R16]
  end

  // read data: counter value mirrors at the reserved addresses
  always_comb begin
    nxt_data_o = data_o_ff;
    if (rd_act) begin
      unique case (adr)
        ADR_EV1:                     nxt_data_o = ev1_ff;
        ADR_EV2:                     nxt_data_o = ev2_ff;
        ADR_CYC, ADR_CYC_M1, ADR_CYC_M2: nxt_data_o = cc_ff;                // [R10]
        default:                     nxt_data_o = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rd_act_ff <= 1'b0;
      wr_act_ff <= 1'b0;
      adr_ff    <= 4'h0;
      wdat_ff   <= 8'h00;
      data_o_ff <= 8'h00;
      oe_n_ff   <= 1'b1;
    end else begin
      rd_act_ff <= rd_act;
      wr_act_ff <= wr_act;
      if (rd_act || wr_act)
        adr_ff <= adr;
      if (wr_act)
        wdat_ff <= data_i;
      data_o_ff <= nxt_data_o;
      oe_n_ff   <= !rd_act;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      en1_ff   <= EN_RESET;                                                 // [R02]
      en2_ff   <= EN_RESET;                                                 // [R02]
      ev1_ff   <= EV_RESET;
      ev2_ff   <= EV_RESET;
      irq_ff   <= 1'b0;
      cc_ff    <= CC_RESET;
      cc_st_ff <= CC_IDLE;
    end else begin
      en1_ff   <= nxt_en1;
      en2_ff   <= nxt_en2;
      ev1_ff   <= nxt_ev1;
      ev2_ff   <= nxt_ev2;
      irq_ff   <= nxt_irq;
      cc_ff    <= nxt_cc;
      cc_st_ff <= nxt_cc_st;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      div_ff <= '0;
      ba_ff  <= 1'b0;
      clr_ff <= 1'b0;
      rr_ff  <= 8'h00;
    end else begin
      div_ff <= nxt_div;
      ba_ff  <= nxt_ba;
      clr_ff <= nxt_clr;
      rr_ff  <= nxt_rr;
    end
  end

  assign data_o                    = data_o_ff;
  assign data_oe_n                 = oe_n_ff;
  assign irq_n                     = !irq_ff;
  assign bus_active                = ba_ff;
  assign process_data_clear        = clr_ff;
  assign external_register_reset_n = (rr_ff == 8'h00);

endmodule
`default_nettype wire

// >>> sim/fsil_top_assertions.sv
// checker for fsil_top: read port, request line, bus-active and timeout pulse
// assumes it is bound to fsil_top and sees only its ports
`timescale 1ns/1ps
`default_nettype none
module fsil_top_checker
  import fsil_pkg::*;
#(
  parameter int unsigned WD_W = 16
) (
  input wire logic            clk,                       // system clock
  input wire logic            rstn,                      // async reset
  input wire logic            cs_n,                      // chip select
  input wire logic            rd_n,                      // read strobe
  input wire logic            wr_n,                      // write strobe
  input wire logic [7:0]      data_o,                    // read data
  input wire logic            data_oe_n,                 // data enable
  input wire logic            irq_n,                     // request line
  input wire fsil_evt_s       evt,                       // bus events
  input wire fsil_lt_sel_e    link_layer_timeout_sel,    // timeout period
  input wire logic [WD_W-1:0] wd_limit_us,               // watchdog period
  input wire logic            bus_active,                // diagnostic
  input wire logic            process_data_clear,        // clear pulse
  input wire logic            external_register_reset_n  // reset pulse
);
  logic [7:0] low_ff;
  logic [7:0] nxt_low;
  logic       wrote_ff;
  logic       nxt_wrote;
  // no enable can be set before the first write, so no request either
  always_comb begin
    nxt_low = external_register_reset_n ? 8'h00 : low_ff + 8'h01;
    nxt_wrote = wrote_ff | (!cs_n && !wr_n);
  end
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      low_ff <= 8'h00;
      wrote_ff <= 1'b0;
    end else begin
      low_ff <= nxt_low;
      wrote_ff <= nxt_wrote;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  sequence s_rd_on; !cs_n && !rd_n; endsequence
  sequence s_rd_off2; (cs_n || rd_n) [*2]; endsequence
  property p_oe_on; s_rd_on |=> !data_oe_n; endproperty
  a_oe_on: assert property (p_oe_on) else $error("data pins idle during read");
  property p_oe_off; (cs_n || rd_n) |=> data_oe_n; endproperty
  a_oe_off: assert property (p_oe_off) else $error("data pins driven after read");
  property p_dout_hold; s_rd_off2 |=> $stable(data_o); endproperty
  a_dout_hold: assert property (p_dout_hold) else $error("read data moved while idle");
  property p_no_early_irq; !wrote_ff |-> irq_n; endproperty
  a_no_early_irq: assert property (p_no_early_irq) else $error("request while masked");
  property p_ba_set; evt.user_update && !evt.bus_reset |=> bus_active; endproperty
  a_ba_set: assert property (p_ba_set) else $error("bus active not set");
  property p_brst; evt.bus_reset && !evt.user_update |=> process_data_clear && !bus_active;
  endproperty
  a_brst: assert property (p_brst) else $error("bus reset not applied");
  property p_clr_pulse; process_data_clear |=> !process_data_clear; endproperty
  a_clr_pulse: assert property (p_clr_pulse) else $error("clear pulse too long");
  property p_ba_drop;
    $fell(bus_active) |-> $past(evt.bus_reset) || (wd_limit_us != '0);
  endproperty
  a_ba_drop: assert property (p_ba_drop) else $error("bus active dropped");
  property p_external_register_reset_n_len; $rose(external_register_reset_n) |-> low_ff == 8'(EXTERNAL_REGISTER_RESET_N_CYC);
  endproperty
  a_external_register_reset_n_len: assert property (p_external_register_reset_n_len) else $error("reset pulse width");
  property p_external_register_reset_n_sel;
    $fell(external_register_reset_n) |-> link_layer_timeout_sel != FSIL_LT_OFF;
  endproperty
  a_external_register_reset_n_sel: assert property (p_external_register_reset_n_sel) else $error("timeout while off");
endmodule
bind fsil_top fsil_top_checker #(.WD_W(WD_W)) fsil_top_checker_inst (
  .clk(clk), .rstn(rstn), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n), .data_o(data_o),
  .data_oe_n(data_oe_n), .irq_n(irq_n), .evt(evt),
  .link_layer_timeout_sel(link_layer_timeout_sel), .wd_limit_us(wd_limit_us),
  .bus_active(bus_active), .process_data_clear(process_data_clear),
  .external_register_reset_n(external_register_reset_n));
`default_nettype wire

// >>> sim/fsil_master_model.sv
// fieldbus master model: one-cycle cycle events and the timeout period
// assumes the bench calls its tasks; events change on the falling edge
`timescale 1ns/1ps
`default_nettype none
module fsil_master_model
  import fsil_pkg::*;
(
  input  wire logic       clk,    // system clock
  output var fsil_evt_s    evt,    // cycle events
  output var fsil_lt_sel_e lt_sel  // timeout period
);
  initial begin
    evt = '0;
    lt_sel = FSIL_LT_OFF;
  end
  // kind: 0 valid, 1 valid idle, 2 invalid, 3 id, 4 check, 5 reset, 6 update
  task automatic cycle(input logic [2:0] k);
    @(negedge clk);
    evt.data_valid = (k == 3'h0) || (k == 3'h1);
    evt.idle_bit = (k == 3'h1);
    evt.data_invalid = (k == 3'h2);
    evt.id_end = (k == 3'h3);
    evt.check_seq = (k == 3'h4);
    evt.bus_reset = (k == 3'h5);
    evt.user_update = (k == 3'h6);
    @(negedge clk);
    evt = '0;
  endtask
  // only the master sets the period
  task automatic set_period(input fsil_lt_sel_e s);
    @(negedge clk);
    lt_sel = s;
  endtask
endmodule
`default_nettype wire

// >>> sim/fsil_top_tb.sv
// self-checking bench for fsil_top acting as the local processor
// assumes shortened tick and timeout parameters; master model drives events
`timescale 1ns/1ps
`default_nettype none
module fsil_top_tb;
  import fsil_pkg::*;
  typedef struct packed {
    logic [7:0] en1;
    logic [7:0] en2;
    logic [2:0] kind;
    logic [7:0] ev1;
    logic [7:0] ev2;
  } fsil_row_s;
  logic         clk, rstn, cs_n, rd_n, wr_n, data_oe_n, irq_n, bus_active, pdc, ext_n;
  logic [3:0]   adr;
  logic [7:0]   data_i, data_o;
  logic [15:0]  wd_limit;
  fsil_evt_s    evt;
  fsil_lt_sel_e lt_sel;
  int           error_cnt, check_count, cyc;
  fsil_row_s rows [10] = '{
    '{8'hFF, 8'h03, 3'h0, 8'h02, 8'h02}, '{8'hFF, 8'h03, 3'h1, 8'h06, 8'h02},
    '{8'hFF, 8'h03, 3'h2, 8'h02, 8'h04}, '{8'hFF, 8'h03, 3'h3, 8'h22, 8'h00},
    '{8'hFF, 8'h03, 3'h4, 8'h00, 8'h01}, '{8'hFF, 8'h03, 3'h5, 8'h08, 8'h00},
    '{8'h00, 8'h00, 3'h0, 8'h00, 8'h00}, '{8'h02, 8'h00, 3'h2, 8'h02, 8'h00},
    '{8'h40, 8'h00, 3'h1, 8'h00, 8'h02}, '{8'hBF, 8'h03, 3'h2, 8'h02, 8'h00}};
  fsil_lt_sel_e sels [3] = '{FSIL_LT_SHORT, FSIL_LT_MID, FSIL_LT_LONG};
  int           tks [3] = '{32'h5, 32'hA, 32'h14};
  fsil_top #(.TICK_CYCLES(4), .LT_SHORT_TICKS(5), .LT_MID_TICKS(10), .LT_LONG_TICKS(20))
  fsil_top_inst (.clk(clk), .rstn(rstn), .adr(adr), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n),
    .data_i(data_i), .data_o(data_o), .data_oe_n(data_oe_n), .irq_n(irq_n), .evt(evt),
    .link_layer_timeout_sel(lt_sel), .wd_limit_us(wd_limit), .bus_active(bus_active),
    .process_data_clear(pdc), .external_register_reset_n(ext_n));
  fsil_master_model fsil_master_model_inst (.clk(clk), .evt(evt), .lt_sel(lt_sel));
  task automatic conclude();
    if (error_cnt == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(negedge clk);
    adr = a;
    data_i = d;
    cs_n = 1'b0;
    wr_n = 1'b0;
    @(negedge clk);
    cs_n = 1'b1;
    wr_n = 1'b1;
    @(negedge clk);
  endtask
  // answer arrives one cycle after the strobe is seen; clear lands on release
  task automatic rdc(input string name, input logic [3:0] a, input logic [7:0] e);
    @(negedge clk);
    adr = a;
    cs_n = 1'b0;
    rd_n = 1'b0;
    @(negedge clk);
    chk(name, data_o, e);
    cs_n = 1'b1;
    rd_n = 1'b1;
    @(negedge clk);
  endtask
  task automatic wait_low(ref logic s, output int n);
    n = 0;
    while (s !== 1'b0 && n < 400) begin
      @(negedge clk);
      n++;
    end
  endtask
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      conclude();
    end
  end
  initial begin
    int n;
    {rstn, adr, data_i, wd_limit} = '0;
    {cs_n, rd_n, wr_n} = 3'h7;
    repeat (5) @(posedge clk);
    @(negedge clk);
    rstn = 1'b1;
    chk("irq_n", {7'h00, irq_n}, 8'h01);
    chk("reset_out", {7'h00, ext_n}, 8'h01);
    fsil_master_model_inst.cycle(3'h1);
    @(negedge clk);
    chk("irq_n", {7'h00, irq_n}, 8'h01);
    rdc("unmapped", 4'h7, 8'h00);
    rdc("cycle_count", ADR_CYC, 8'h00);
    foreach (rows[i]) begin
      wr(ADR_EN1, rows[i].en1);
      wr(ADR_EN2, rows[i].en2);
      fsil_master_model_inst.cycle(rows[i].kind);
      @(negedge clk);
      chk("irq_n", {7'h00, irq_n}, {7'h00, (rows[i].ev1 | rows[i].ev2) == 8'h00});
      // event registers are read only after a request, bus reset included
      if (irq_n === 1'b0) begin
        rdc("event_first", ADR_EV1, rows[i].ev1);
        chk("irq_n", {7'h00, irq_n}, {7'h00, rows[i].ev2 == 8'h00});
        rdc("event_second", ADR_EV2, rows[i].ev2);
      end
      chk("irq_n", {7'h00, irq_n}, 8'h01);
    end
    wr(ADR_EN1, 8'h10);
    wr(ADR_CYC, 8'h03);
    rdc("cycle_count", ADR_CYC, 8'h03);
    rdc("cycle_mirror", ADR_CYC_M1, 8'h03);
    fsil_master_model_inst.cycle(3'h0);
    fsil_master_model_inst.cycle(3'h2);
    rdc("cycle_count", ADR_CYC, 8'h02);
    rdc("cycle_mirror", ADR_CYC_M2, 8'h02);
    fsil_master_model_inst.cycle(3'h0);
    @(negedge clk);
    chk("irq_n", {7'h00, irq_n}, 8'h01);
    fsil_master_model_inst.cycle(3'h0);
    @(negedge clk);
    rdc("event_first", ADR_EV1, 8'h10);
    rdc("cycle_count", ADR_CYC, 8'h00);
    wr(ADR_EN1, 8'h01);
    wd_limit = 16'h000A;
    fsil_master_model_inst.cycle(3'h6);
    chk("bus_active", {7'h00, bus_active}, 8'h01);
    wait_low(irq_n, n);
    chk("watchdog_span", {7'h00, n >= 32'h20 && n < 32'h3C}, 8'h01);
    chk("bus_active", {7'h00, bus_active}, 8'h00);
    rdc("event_first", ADR_EV1, 8'h01);
    wd_limit = 16'h0000;
    wr(ADR_EN1, 8'h00);
    wr(ADR_EN2, 8'h02);
    foreach (sels[i]) begin
      fsil_master_model_inst.set_period(sels[i]);
      fsil_master_model_inst.cycle(3'h0);
      wait_low(ext_n, n);
      // clear pulse and reset pulse start on the same edge
      chk("data_clear", {7'h00, pdc}, 8'h01);
      chk("timeout_span", {7'h00, n + 32'h4 >= tks[i] * 4 && n <= tks[i] * 4 + 8}, 8'h01);
      rdc("event_second", ADR_EV2, 8'h08);
      repeat (100) @(negedge clk);
    end
    fsil_master_model_inst.set_period(FSIL_LT_OFF);
    fsil_master_model_inst.cycle(3'h0);
    repeat (120) @(negedge clk);
    chk("reset_out", {7'h00, ext_n}, 8'h01);
    chk("irq_n", {7'h00, irq_n}, 8'h01);
    // a reset in mid-run must mask every source again
    wr(ADR_EN1, 8'hFF);
    @(negedge clk);
    rstn = 1'b0;
    @(negedge clk);
    rstn = 1'b1;
    chk("reset_out", {7'h00, ext_n}, 8'h01);
    fsil_master_model_inst.cycle(3'h1);
    @(negedge clk);
    chk("irq_n", {7'h00, irq_n}, 8'h01);
    conclude();
  end
endmodule
`default_nettype wire
